// *** design/lcd_scan_defines.svh ***
`ifndef LCD_SCAN_DEFINES_SVH
`define LCD_SCAN_DEFINES_SVH

// Register byte offsets.
`define OFS_COMMAND 8'h00
`define OFS_DATA 8'h04
`define OFS_CONFIG 8'h08
`define OFS_POINTER 8'h0c
`define OFS_STATUS 8'h10

// Configuration register field positions.
`define CFG_VERTICAL 0
`define CFG_COL_MIRROR 1
`define CFG_ROW_REVERSE 2
`define CFG_IFACE_FLIP 3
`define CFG_FAR_FLIP 4
`define CFG_BIT_ORDER 5
`define CFG_MUX33 6
`define CFG_POWER_DOWN 7
`define CFG_PUMP_LO 8
`define CFG_SLOPE_LO 10
`define CFG_BIAS_LO 12
`define CFG_RANGE_SEL 15
`define CFG_VOP_LO 16
`define CFG_DISP_E 23
`define CFG_DISP_D 24

// Reset value: everything zero except power-down.
`define CFG_RESET 25'h0000080

// Address space of the display memory.
`define LAST_COLUMN 7'h7f
`define LAST_BANK 4'h8
`define ICON_ROW 7'h40
`define LAST_ROW65 7'h40
`define LAST_COL65 8'h7f
`define LAST_COL33 8'h9f
`define MEM_DEPTH 1152

// Internal display oscillator: one tick every OSC_DIV clock cycles.
`define OSC_PERIOD_NS 100
`define CLK_PERIOD_NS 25
`define OSC_DIV ((`OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** design/lcd_scan_pkg.sv ***
package lcd_scan_pkg;

    typedef enum logic [1:0] {
        SCAN_OFF = 2'b00,
        SCAN_RUN = 2'b01
    } scan_state_e;

    typedef logic [10:0] mem_addr_t;

endpackage

// *** design/display_ram.sv ***
`timescale 1ns/1ps
module display_ram (
    // Clock
    input wire logic mclk,
    // Write port
    input wire logic writeEnable,
    input wire lcd_scan_pkg::mem_addr_t writeAddr,
    input wire logic [7:0] writeData,
    // Read port
    input wire lcd_scan_pkg::mem_addr_t readAddr,
    output logic [7:0] readData
);
`include "lcd_scan_defines.svh"

    logic [7:0] cells [0:`MEM_DEPTH-1];

    // Contents are never cleared; only writes change them.
    always_ff @(posedge mclk) begin
        if (writeEnable) begin
            cells[writeAddr] <= writeData;
        end
    end

    always_ff @(posedge mclk) begin
        readData <= cells[readAddr];
    end

endmodule

// *** design/lcd_ram_addressing_and_scan_map.sv ***
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module lcd_ram_addressing_and_scan_map (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // Pins
    input wire logic initPulseN,
    input wire logic useExtClk,
    input wire logic extClk,
    // Scan output
    output logic pixelValid,
    output logic pixelData,
    output logic [7:0] pixelColumn,
    output logic [6:0] rowPad,
    output logic rowAsColumn,
    // Analog control
    output logic driversEnable,
    output logic biasEnable,
    output logic pumpEnable,
    output logic pumpDischarge,
    output logic [1:0] pumpFactor,
    output logic [1:0] tempSlope,
    output logic [2:0] biasRatioField,
    output logic voltageRangeSelect,
    output logic [6:0] voltageSetting,
    output logic oscRunning
);
`include "lcd_scan_defines.svh"

    // Pin synchronisers.
    logic initMeta, initSync;
    logic strapMeta, strapSync;
    logic extMeta, extSync, extPrev;

    always_ff @(posedge mclk) begin
        initMeta <= initPulseN;
        initSync <= initMeta;
        strapMeta <= useExtClk;
        strapSync <= strapMeta;
        extMeta <= extClk;
        extSync <= extMeta;
        extPrev <= extSync;
    end

    logic initActive;
    assign initActive = reset || !initSync;

    // Configuration state.
    logic [24:0] cfgReg;
    logic [6:0] ptrX;
    logic [3:0] ptrY;

    logic vertical, colMirror, rowReadReverse, ifaceFlip, farFlip;
    logic byteBitOrder, mux33, powerDown, genOn;
    assign vertical = cfgReg[`CFG_VERTICAL];
    assign colMirror = cfgReg[`CFG_COL_MIRROR];
    assign rowReadReverse = cfgReg[`CFG_ROW_REVERSE];
    assign ifaceFlip = cfgReg[`CFG_IFACE_FLIP];
    assign farFlip = cfgReg[`CFG_FAR_FLIP];
    assign byteBitOrder = cfgReg[`CFG_BIT_ORDER];
    assign mux33 = cfgReg[`CFG_MUX33];
    assign powerDown = cfgReg[`CFG_POWER_DOWN];

    logic cmdWrite, dataWrite;
    assign cmdWrite = regWrite && !initActive && regAddr == `OFS_COMMAND;
    assign dataWrite = regWrite && !initActive && regAddr == `OFS_DATA;

    always_ff @(posedge mclk) begin
        if (initActive) begin
            cfgReg <= `CFG_RESET;
        end else if (regWrite && regAddr == `OFS_CONFIG) begin
            cfgReg <= regWdata[24:0];
        end else if (cmdWrite && regWdata[7:1] == 7'h10) begin
            cfgReg[`CFG_POWER_DOWN] <= regWdata[0];
        end
    end

    // Pointer walk for one data byte: returns {y, x}.
    function automatic logic [10:0] nextPointer(input logic [6:0] x,
                                                input logic [3:0] y,
                                                input logic vert);
        logic [6:0] nx;
        logic [3:0] ny;
        nx = x;
        ny = y;
        if (!vert) begin
            if (x == `LAST_COLUMN) begin
                nx = 7'h00;
                ny = (y == `LAST_BANK) ? 4'h0 : y + 4'h1;
            end else begin
                nx = x + 7'h01;
            end
        end else begin
            if (y == `LAST_BANK) begin
                ny = 4'h0;
                nx = (x == `LAST_COLUMN) ? 7'h00 : x + 7'h01;
            end else begin
                ny = y + 4'h1;
            end
        end
        return {ny, nx};
    endfunction

    always_ff @(posedge mclk) begin
        if (initActive) begin
            ptrX <= 7'h00;
            ptrY <= 4'h0;
        end else if (dataWrite) begin
            {ptrY, ptrX} <= nextPointer(ptrX, ptrY, vertical);
        end else if (cmdWrite && regWdata[7]) begin
            ptrX <= regWdata[6:0];
        end else if (cmdWrite && regWdata[7:4] == 4'h4 &&
                     regWdata[3:0] <= `LAST_BANK) begin
            ptrY <= regWdata[3:0];
        end
    end

    // Data bytes are stored so that stored bit k is row k of the bank.
    logic [7:0] storeByte;
    logic [6:0] physX;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            storeByte[i] = byteBitOrder ? regWdata[i] : regWdata[7-i];
        end
    end
    assign physX = colMirror ? `LAST_COLUMN - ptrX : ptrX;

    // Scan engine.
    lcd_scan_pkg::scan_state_e scanState;
    logic [7:0] divCnt;
    logic oscTick, scanTick;
    logic [6:0] step;
    logic [7:0] col;
    logic [6:0] lastStep;
    logic [7:0] lastCol;

    always_ff @(posedge mclk) begin
        if (initActive || powerDown || strapSync) begin
            divCnt <= 8'h00;
        end else if (divCnt == 8'(`OSC_DIV - 1)) begin
            divCnt <= 8'h00;
        end else begin
            divCnt <= divCnt + 8'h01;
        end
    end

    assign oscTick = !powerDown && !strapSync &&
                     divCnt == 8'(`OSC_DIV - 1);
    assign scanTick = strapSync ? (extSync && !extPrev) : oscTick;
    assign oscRunning = !powerDown && !strapSync;

    always_ff @(posedge mclk) begin
        if (initActive || powerDown) begin
            scanState <= lcd_scan_pkg::SCAN_OFF;
        end else begin
            scanState <= lcd_scan_pkg::SCAN_RUN;
        end
    end

    always_comb begin
        if (mux33) begin
            lastStep = rowReadReverse ? 7'd32 : 7'd33;
            lastCol = `LAST_COL33;
        end else begin
            lastStep = `LAST_ROW65;
            lastCol = `LAST_COL65;
        end
    end

    always_ff @(posedge mclk) begin
        if (initActive || scanState == lcd_scan_pkg::SCAN_OFF) begin
            step <= 7'd0;
            col <= 8'h00;
        end else if (scanTick) begin
            if (col >= lastCol) begin
                col <= 8'h00;
                step <= (step >= lastStep) ? 7'd0 : step + 7'd1;
            end else begin
                col <= col + 8'h01;
            end
        end
    end

    // Map the scan position onto a memory row, column and blank flag.
    logic [5:0] logRow;
    logic [6:0] memRow;
    logic [6:0] memCol;
    logic blankPix;
    always_comb begin
        logRow = step[5:0];
        memRow = step;
        memCol = col[6:0];
        blankPix = 1'b0;
        if (!mux33) begin
            if (rowReadReverse && step != `ICON_ROW) begin
                memRow = 7'd63 - step;
            end
        end else begin
            if (rowReadReverse) begin
                logRow = (step == 7'd32) ? 6'd33 : 6'd32 - step[5:0];
            end
            if (logRow == 6'd33) begin
                memRow = `ICON_ROW;
                memCol = 7'(col - 8'd16);
                blankPix = col < 8'd16 || col > 8'd143;
            end else if (logRow == 6'd32) begin
                blankPix = 1'b1;
            end else if (col < 8'd16) begin
                memRow = 7'(logRow);
                memCol = col[6:0];
            end else if (col > 8'd143) begin
                memRow = 7'(logRow);
                memCol = 7'(col - 8'd32);
            end else begin
                memRow = 7'(logRow) + 7'd32;
                memCol = 7'(col - 8'd16);
            end
        end
    end

    // Driver index to pad on each edge.
    logic [6:0] padIndex;
    always_comb begin
        padIndex = step;
        if (step < 7'd32 && ifaceFlip) begin
            padIndex = 7'd31 - step;
        end else if (step >= 7'd32 && step < 7'd64 && farFlip) begin
            padIndex = 7'd95 - step;
        end
    end

    logic [7:0] memData;
    lcd_scan_pkg::mem_addr_t readAddr;
    assign readAddr = {memRow[6:3], memCol};

    display_ram ram (
        .mclk(mclk),
        .writeEnable(dataWrite),
        .writeAddr({ptrY, physX}),
        .writeData(storeByte),
        .readAddr(readAddr),
        .readData(memData)
    );

    // Pipeline stage aligned with the memory read.
    logic issueValid, issueBlank;
    logic [2:0] issueBit;
    logic [7:0] issueCol;
    logic [6:0] issuePad;

    always_ff @(posedge mclk) begin
        if (initActive) begin
            issueValid <= 1'b0;
            issueBlank <= 1'b0;
            issueBit <= 3'd0;
            issueCol <= 8'h00;
            issuePad <= 7'h00;
        end else begin
            issueValid <= scanTick && scanState == lcd_scan_pkg::SCAN_RUN;
            issueBlank <= blankPix;
            issueBit <= memRow[2:0];
            issueCol <= col;
            issuePad <= padIndex;
        end
    end

    logic dispE, dispD, rawPix;
    assign dispE = cfgReg[`CFG_DISP_E];
    assign dispD = cfgReg[`CFG_DISP_D];
    assign rawPix = !issueBlank && memData[issueBit];

    always_ff @(posedge mclk) begin
        if (initActive) begin
            pixelValid <= 1'b0;
            pixelData <= 1'b0;
            pixelColumn <= 8'h00;
            rowPad <= 7'h00;
        end else begin
            pixelValid <= issueValid;
            pixelColumn <= issueCol;
            rowPad <= issuePad;
            pixelData <= dispD ? (dispE ? !rawPix : 1'b1)
                               : (dispE ? rawPix : 1'b0);
        end
    end

    // Analog control outputs.
    assign genOn = cfgReg[`CFG_VOP_LO +: 7] != 7'h00 ||
                   cfgReg[`CFG_RANGE_SEL];
    always_ff @(posedge mclk) begin
        if (initActive) begin
            driversEnable <= 1'b0;
            biasEnable <= 1'b0;
            pumpEnable <= 1'b0;
            pumpDischarge <= 1'b1;
            rowAsColumn <= 1'b0;
            pumpFactor <= 2'b00;
            tempSlope <= 2'b00;
            biasRatioField <= 3'b000;
            voltageRangeSelect <= 1'b0;
            voltageSetting <= 7'h00;
        end else begin
            driversEnable <= !powerDown;
            biasEnable <= !powerDown;
            pumpEnable <= !powerDown && genOn;
            pumpDischarge <= powerDown || !genOn;
            rowAsColumn <= mux33;
            pumpFactor <= cfgReg[`CFG_PUMP_LO +: 2];
            tempSlope <= cfgReg[`CFG_SLOPE_LO +: 2];
            biasRatioField <= cfgReg[`CFG_BIAS_LO +: 3];
            voltageRangeSelect <= cfgReg[`CFG_RANGE_SEL];
            voltageSetting <= cfgReg[`CFG_VOP_LO +: 7];
        end
    end

    // Register reads answer one cycle later; unmapped reads give zero.
    always_ff @(posedge mclk) begin
        if (reset) begin
            regRdata <= 32'h0;
        end else if (regRead) begin
            if (regAddr == `OFS_CONFIG) begin
                regRdata <= {7'h0, cfgReg};
            end else if (regAddr == `OFS_POINTER) begin
                regRdata <= {21'h0, ptrY, ptrX};
            end else if (regAddr == `OFS_STATUS) begin
                regRdata <= {14'h0, col, 1'b0, step,
                             genOn, scanState == lcd_scan_pkg::SCAN_RUN};
            end else begin
                regRdata <= 32'h0;
            end
        end else begin
            regRdata <= 32'h0;
        end
    end

endmodule

// *** testbench/ext_osc_model.sv ***
`timescale 1ns/1ps
module ext_osc_model (
    // Control
    input wire logic run,
    // Clock out
    output logic extClk
);
    // The clock stands low while the display runs from its own oscillator.
    initial extClk = 1'b0;
    always #60 extClk = run ? ~extClk : 1'b0;
endmodule

// *** testbench/lcd_scan_asserts.sv ***
`timescale 1ns/1ps
module lcd_scan_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Observed ports
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic pixelValid,
    input wire logic [7:0] pixelColumn,
    input wire logic rowAsColumn,
    input wire logic driversEnable,
    input wire logic biasEnable,
    input wire logic pumpEnable,
    input wire logic pumpDischarge,
    input wire logic voltageRangeSelect,
    input wire logic [6:0] voltageSetting,
    input wire logic oscRunning
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdata == 32'h0)
        else $error("read data not zero outside read slot");
    AST_BIAS_PD: assert property (biasEnable == driversEnable)
        else $error("bias enable differs from driver enable");
    AST_DISCHARGE: assert property (pumpDischarge != pumpEnable)
        else $error("pump discharge not inverse of pump enable");
    AST_GEN_OFF: assert property (pumpEnable |-> driversEnable &&
        (voltageSetting != 7'h00 || voltageRangeSelect))
        else $error("generator on with zero setting or power down");
    AST_GEN_ON: assert property (driversEnable &&
        (voltageSetting != 7'h00 || voltageRangeSelect) |-> pumpEnable)
        else $error("generator off with nonzero setting");
    AST_OSC_PD: assert property (!driversEnable [*4] |->
        !$past(oscRunning))
        else $error("oscillator runs in power down");
    AST_PIX_PD: assert property (!driversEnable [*4] |-> !pixelValid)
        else $error("pixels leave in power down");
    AST_COL65: assert property (!rowAsColumn [*4] ##0 pixelValid |->
        pixelColumn <= 8'h7f)
        else $error("column past 127 in 65 row mode");
    AST_COL33: assert property (pixelValid |-> pixelColumn <= 8'h9f)
        else $error("column past 159");
    AST_PIX_PULSE: assert property (pixelValid |=> !pixelValid)
        else $error("pixel strobe longer than one cycle");
    cover property (pixelValid && rowAsColumn);
    cover property (pumpEnable);
    cover property (regRead ##1 regRdata != 32'h0);
endmodule

bind lcd_ram_addressing_and_scan_map lcd_scan_asserts u_lcd_scan_asserts (
    .mclk(mclk), .reset(reset), .regRead(regRead), .regRdata(regRdata),
    .pixelValid(pixelValid), .pixelColumn(pixelColumn),
    .rowAsColumn(rowAsColumn), .driversEnable(driversEnable),
    .biasEnable(biasEnable), .pumpEnable(pumpEnable),
    .pumpDischarge(pumpDischarge), .voltageRangeSelect(voltageRangeSelect),
    .voltageSetting(voltageSetting), .oscRunning(oscRunning));

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`include "lcd_scan_defines.svh"
module testbench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0, regRead = 1'b0, initPulseN = 1'b1, useExtClk = 1'b0;
    logic extClk, pixelValid, pixelData, rowAsColumn, driversEnable;
    logic biasEnable, pumpEnable, pumpDischarge, voltageRangeSelect, oscRunning;
    logic [31:0] regRdata, d;
    logic [7:0] pixelColumn;
    logic [6:0] rowPad, voltageSetting;
    logic [1:0] pumpFactor, tempSlope;
    logic [2:0] biasRatioField;
    int fails = 0;
    int check_count = 0;
    localparam logic [31:0] ON = 32'h1 << `CFG_DISP_E;
    localparam logic [31:0] PD = 32'h1 << `CFG_POWER_DOWN;
    localparam logic [31:0] VT = 32'h1 << `CFG_VERTICAL;
    localparam logic [31:0] MR = 32'h1 << `CFG_COL_MIRROR;
    localparam logic [31:0] RR = 32'h1 << `CFG_ROW_REVERSE;
    localparam logic [31:0] M33 = 32'h1 << `CFG_MUX33;
    localparam logic [31:0] BO = 32'h1 << `CFG_BIT_ORDER;
    localparam logic [31:0] IFL = 32'h1 << `CFG_IFACE_FLIP;
    localparam logic [31:0] FFL = 32'h1 << `CFG_FAR_FLIP;
    always #12.5 mclk = ~mclk;
    lcd_ram_addressing_and_scan_map u_lcd_ram_addressing_and_scan_map (
        .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .initPulseN(initPulseN), .useExtClk(useExtClk), .extClk(extClk),
        .pixelValid(pixelValid), .pixelData(pixelData),
        .pixelColumn(pixelColumn), .rowPad(rowPad),
        .rowAsColumn(rowAsColumn), .driversEnable(driversEnable),
        .biasEnable(biasEnable), .pumpEnable(pumpEnable),
        .pumpDischarge(pumpDischarge), .pumpFactor(pumpFactor),
        .tempSlope(tempSlope), .biasRatioField(biasRatioField),
        .voltageRangeSelect(voltageRangeSelect),
        .voltageSetting(voltageSetting), .oscRunning(oscRunning));
    ext_osc_model u_ext_osc_model (.run(useExtClk), .extClk(extClk));
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic setp(logic [6:0] x, logic [3:0] y);
        wr(`OFS_COMMAND, {24'h0, 1'b1, x});
        wr(`OFS_COMMAND, {24'h0, 4'h4, y});
    endtask
    task automatic put(logic [31:0] cfg, logic [6:0] x, logic [3:0] y,
                       logic [31:0] v);
        wr(`OFS_CONFIG, cfg | PD);
        setp(x, y);
        wr(`OFS_DATA, v);
    endtask
    task automatic walk(logic [31:0] cfg, logic [6:0] x, logic [3:0] y,
                        logic [6:0] ex, logic [3:0] ey);
        put(cfg, x, y, 32'h5a);
        rd(`OFS_POINTER);
        check("pointer", d, {21'h0, ey, ex});
    endtask
    task automatic waitPix(int n);
        int left;
        left = n;
        for (int k = 0; k < 8 * n + 400; k++) begin
            @(posedge mclk);
            #1;
            if (pixelValid === 1'b1) left--;
            if (left == 0) return;
        end
        fails++;
        end_sim();
    endtask
    task automatic scan(logic [31:0] cfg, logic [6:0] pad, logic pix,
                        logic asCol, int row);
        wr(`OFS_CONFIG, cfg | ON | PD);
        wr(`OFS_CONFIG, cfg | ON);
        waitPix(row * 128 + 1);
        check("column", pixelColumn, 32'h0);
        if (pad != 7'h7f) check("pad", rowPad, pad);
        check("pixel", pixelData, pix);
        check("rowcol", rowAsColumn, asCol);
    endtask
    task automatic s_reset();
        rd(`OFS_CONFIG);
        check("config", d, `CFG_RESET);
        rd(`OFS_POINTER);
        check("pointer", d, 32'h0);
        rd(8'h3c);
        check("unmapped", d, 32'h0);
        check("discharge", pumpDischarge, 32'h1);
        check("drivers", driversEnable, 32'h0);
        check("pump", pumpFactor, 32'h0);
    endtask
    task automatic s_walks();
        walk(32'h0, 7'h7f, 4'h0, 7'h00, 4'h1);
        walk(VT, 7'h05, 4'h8, 7'h06, 4'h0);
        walk(MR, 7'h7f, 4'h2, 7'h00, 4'h3);
        walk(MR | VT, 7'h10, 4'h3, 7'h10, 4'h4);
        walk(32'h0, 7'h7f, 4'h8, 7'h00, 4'h0);
        walk(VT, 7'h7f, 4'h8, 7'h00, 4'h0);
        walk(M33, 7'h7f, 4'h5, 7'h00, 4'h6);
    endtask
    task automatic s_analog();
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_CONFIG, ON | (i << `CFG_PUMP_LO) | (i << `CFG_SLOPE_LO));
            settle();
            check("pump", pumpFactor, 32'(i));
            check("slope", tempSlope, 32'(i));
        end
        wr(`OFS_CONFIG, ON | (32'h5 << `CFG_BIAS_LO));
        settle();
        check("bias", biasRatioField, 32'h5);
        check("genoff", pumpEnable, 32'h0);
        check("osc", oscRunning, 32'h1);
        wr(`OFS_CONFIG, ON | (32'h7 << `CFG_VOP_LO));
        settle();
        check("genon", pumpEnable, 32'h1);
        check("vop", voltageSetting, 32'h7);
        wr(`OFS_CONFIG, ON | (32'h1 << `CFG_RANGE_SEL));
        settle();
        check("range", pumpEnable, 32'h1);
        check("rangesel", voltageRangeSelect, 32'h1);
        wr(`OFS_CONFIG, ON | PD | (32'h7 << `CFG_VOP_LO));
        settle();
        check("pdpump", pumpDischarge, 32'h1);
        check("pdbias", biasEnable, 32'h0);
        check("pdosc", oscRunning, 32'h0);
        wr(`OFS_COMMAND, 32'h20);
        settle();
        check("cmdpd", driversEnable, 32'h1);
    endtask
    task automatic s_scan();
        put(MR, 7'h7f, 4'h0, 32'h80);
        put(32'h0, 7'h00, 4'h7, 32'h01);
        put(32'h0, 7'h00, 4'h4, 32'h80);
        scan(32'h0, 7'd0, 1'b1, 1'b0, 0);
        scan(RR, 7'd0, 1'b1, 1'b0, 0);
        scan(IFL, 7'd31, 1'b1, 1'b0, 0);
        scan(FFL, 7'd63, 1'b1, 1'b0, 32);
        scan(M33, 7'h7f, 1'b1, 1'b1, 0);
        scan(M33 | RR, 7'h7f, 1'b0, 1'b1, 0);
        put(BO, 7'h00, 4'h0, 32'h80);
        scan(BO, 7'd0, 1'b0, 1'b0, 0);
    endtask
    task automatic s_ext();
        wr(`OFS_CONFIG, PD);
        useExtClk <= 1'b1;
        scan(RR, 7'd0, 1'b1, 1'b0, 0);
        check("extosc", oscRunning, 32'h0);
        wr(`OFS_CONFIG, PD);
        useExtClk <= 1'b0;
    endtask
    task automatic s_init();
        wr(`OFS_CONFIG, ON | VT);
        setp(7'h05, 4'h3);
        @(posedge mclk);
        initPulseN <= 1'b0;
        repeat (4) @(posedge mclk);
        initPulseN <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(`OFS_CONFIG);
        check("initcfg", d, `CFG_RESET);
        rd(`OFS_POINTER);
        check("initptr", d, 32'h0);
        check("initpd", driversEnable, 32'h0);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        s_reset();
        s_walks();
        s_analog();
        s_scan();
        s_ext();
        s_init();
        end_sim();
    end
endmodule
